/* File: pkg/mdc_params.svh */
`ifndef MDC_PARAMS_SVH
`define MDC_PARAMS_SVH
// ****************************************
// Counts and encodings
// ****************************************
`define MDC_NUM_CH 7
`define MDC_NUM_CTRL 2
`define MDC_CNT_W 17
`define MDC_MAX_ITEMS 17'h1_0000
`define MDC_FIFO_DEPTH 8
`define MDC_SIZE_BYTE 2'h0
`define MDC_SIZE_HALF 2'h1
`define MDC_SIZE_WORD 2'h2
`define MDC_PRIO_LOW 2'h0
`define MDC_PRIO_VHIGH 2'h3
`endif

/* File: pkg/mdc_pkg.sv */
package mdc_pkg;
  typedef enum logic [3:0] {
    MDC_IDLE = 4'b0001,
    MDC_READ = 4'b0010,
    MDC_WRITE = 4'b0100,
    MDC_DONE = 4'b1000
  } mdc_state_e;
  typedef logic [1:0] mdc_size_t;
endpackage

/* File: verilog/mdc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module mdc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // Handshakes; full and empty from the occupancy count
  assign in_ready = (cnt_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = cnt_reg != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_reg];

  // Storage has no reset so it can map to RAM
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // mdc_fifo
`default_nettype wire

/* File: verilog/mdc_controller.sv */
// How it works
// - Seven channels per controller; instantiate twice for fourteen.
// - Each channel starts from its hardware request or a software trigger.
// - Arbiter ranks requests by two-bit priority: very high to low.
// - Equal priority goes to the lower-numbered channel.
// - Source and destination widths independent; data zero-extended or truncated, never packed.
// - Circular mode reloads count and addresses after the last item.
// - Half, complete and error flags ORed into one irq per channel.
// - Direction set by addresses: memory or peripheral either side.
// - Item count programmable up to 65536.
// - Any bus target may be source or destination.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_params.svh"
module mdc_controller import mdc_pkg::*; #(
  parameter int NCH = `MDC_NUM_CH,
  parameter int CW = `MDC_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Per-channel configuration, flattened by channel
  input wire logic [NCH-1:0] ch_enable,
  input wire logic [NCH-1:0] ch_sw_trigger,
  input wire logic [NCH-1:0] ch_circular,
  input wire logic [2*NCH-1:0] ch_priority,
  input wire logic [2*NCH-1:0] ch_src_size,
  input wire logic [2*NCH-1:0] ch_dst_size,
  input wire logic [32*NCH-1:0] ch_src_addr,
  input wire logic [32*NCH-1:0] ch_dst_addr,
  input wire logic [CW*NCH-1:0] ch_items,
  input wire logic [NCH-1:0] ch_flag_clear,
  // Peripheral request lines from outside the clock domain
  input wire logic [NCH-1:0] periph_req,
  // Status
  output logic [NCH-1:0] ch_half_flag,
  output logic [NCH-1:0] ch_done_flag,
  output logic [NCH-1:0] ch_err_flag,
  output logic [NCH-1:0] ch_irq,
  output logic [CW*NCH-1:0] ch_remaining,
  // Bus master port
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic [31:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic [31:0] bus_rdata
);
  // ****************************************
  // Request synchronisers and arbitration
  // ****************************************
  logic [NCH-1:0] req_meta_reg;
  logic [NCH-1:0] req_sync_reg;
  logic [NCH-1:0] pending;
  logic [NCH-1:0] busy_reg;
  logic [2:0] grant_ch;
  logic grant_any;
  mdc_state_e state_reg;
  logic [2:0] cur_reg;

  // Two flops before the request lines are used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_meta_reg <= '0;
      req_sync_reg <= '0;
    end else begin
      req_meta_reg <= periph_req;
      req_sync_reg <= req_meta_reg;
    end
  end

  // Hardware request or software trigger opens a channel
  assign pending = busy_reg & (req_sync_reg | ch_sw_trigger) & ch_enable;

  // Highest level wins; strict > keeps the lowest index on a tie
  always_comb begin
    logic [1:0] best;
    best = `MDC_PRIO_LOW;
    grant_any = 1'b0;
    grant_ch = '0;
    for (int i = 0; i < NCH; i++) begin
      if (pending[i] && (!grant_any || ch_priority[2*i +: 2] > best)) begin
        best = ch_priority[2*i +: 2];
        grant_ch = 3'(i);
        grant_any = 1'b1;
      end
    end
  end

  // ****************************************
  // Transfer engine
  // ****************************************
  logic [31:0] src_reg [NCH];
  logic [31:0] dst_reg [NCH];
  logic [CW-1:0] left_reg [NCH];
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out;
  logic [1:0] ssz;
  logic [1:0] dsz;

  assign ssz = ch_src_size[2*cur_reg +: 2];
  assign dsz = ch_dst_size[2*cur_reg +: 2];

  // Address step for one item of a given width
  function automatic logic [31:0] step(input logic [1:0] sz);
    step = (sz == `MDC_SIZE_WORD) ? 32'h0000_0004 :
           (sz == `MDC_SIZE_HALF) ? 32'h0000_0002 : 32'h0000_0001;
  endfunction

  // Zero-extend narrow reads, truncate on narrow writes
  function automatic logic [31:0] fit(input logic [31:0] d,
                                      input logic [1:0] sz);
    fit = (sz == `MDC_SIZE_WORD) ? d :
          (sz == `MDC_SIZE_HALF) ? {16'h0000, d[15:0]} : {24'h00_0000, d[7:0]};
  endfunction

  // Read data passes the FIFO before it is written out
  mdc_fifo #(.WIDTH(32), .DEPTH(`MDC_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(state_reg == MDC_READ && bus_ack && !bus_err),
    .in_ready(fifo_in_ready),
    .in_data(fit(bus_rdata, ssz)),
    .out_valid(fifo_out_valid),
    .out_ready(state_reg == MDC_WRITE && bus_ack),
    .out_data(fifo_out)
  );

  // Bus drive; reads stall while the FIFO has no room
  assign bus_req = (state_reg == MDC_READ && fifo_in_ready) ||
                   (state_reg == MDC_WRITE && fifo_out_valid);
  assign bus_write = state_reg == MDC_WRITE;
  assign bus_addr = bus_write ? dst_reg[cur_reg] : src_reg[cur_reg];
  assign bus_size = bus_write ? dsz : ssz;
  assign bus_wdata = fit(fifo_out, dsz);

  // One item per grant: read, write, then re-arbitrate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= MDC_IDLE;
      cur_reg <= '0;
    end else begin
      unique case (state_reg)
        MDC_IDLE: begin
          if (grant_any) begin
            cur_reg <= grant_ch;
            state_reg <= MDC_READ;
          end
        end
        MDC_READ: begin
          if (bus_req && bus_ack) begin
            state_reg <= bus_err ? MDC_DONE : MDC_WRITE;
          end
        end
        MDC_WRITE: begin
          if (bus_req && bus_ack) begin
            state_reg <= MDC_DONE;
          end
        end
        MDC_DONE: state_reg <= MDC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Per-channel counters and flags
  // ****************************************
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic mine;
      logic wr_ok;
      logic err_ev;
      logic [CW-1:0] total;
      // A refused write beat moves no item, so it must not count down
      assign mine = cur_reg == 3'(c);
      assign wr_ok = mine && state_reg == MDC_WRITE && bus_req && bus_ack &&
                     !bus_err;
      assign err_ev = mine && bus_req && bus_ack && bus_err;
      assign total = (ch_items[CW*c +: CW] > `MDC_MAX_ITEMS) ?
                     `MDC_MAX_ITEMS : ch_items[CW*c +: CW];
      assign ch_remaining[CW*c +: CW] = left_reg[c];
      assign ch_irq[c] = ch_half_flag[c] | ch_done_flag[c] | ch_err_flag[c];

      // Load on enable; step addresses per item; reload in circular mode
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          busy_reg[c] <= 1'b0;
          left_reg[c] <= '0;
          src_reg[c] <= '0;
          dst_reg[c] <= '0;
        end else if (!ch_enable[c]) begin
          busy_reg[c] <= 1'b0;
        end else if (!busy_reg[c] && !ch_done_flag[c] && !ch_err_flag[c]) begin
          busy_reg[c] <= total != '0;
          left_reg[c] <= total;
          src_reg[c] <= ch_src_addr[32*c +: 32];
          dst_reg[c] <= ch_dst_addr[32*c +: 32];
        end else if (err_ev) begin
          busy_reg[c] <= 1'b0;
        end else if (wr_ok) begin
          if (left_reg[c] == CW'(1) && ch_circular[c]) begin
            left_reg[c] <= total;
            src_reg[c] <= ch_src_addr[32*c +: 32];
            dst_reg[c] <= ch_dst_addr[32*c +: 32];
          end else begin
            left_reg[c] <= left_reg[c] - 1'b1;
            busy_reg[c] <= left_reg[c] != CW'(1);
            src_reg[c] <= src_reg[c] + step(ch_src_size[2*c +: 2]);
            dst_reg[c] <= dst_reg[c] + step(ch_dst_size[2*c +: 2]);
          end
        end
      end

      // Sticky flags; a new event wins over a same-cycle clear
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ch_half_flag[c] <= 1'b0;
          ch_done_flag[c] <= 1'b0;
          ch_err_flag[c] <= 1'b0;
        end else begin
          if (wr_ok && left_reg[c] - 1'b1 == total >> 1) begin
            ch_half_flag[c] <= 1'b1;
          end else if (ch_flag_clear[c]) begin
            ch_half_flag[c] <= 1'b0;
          end
          if (wr_ok && left_reg[c] == CW'(1)) begin
            ch_done_flag[c] <= 1'b1;
          end else if (ch_flag_clear[c]) begin
            ch_done_flag[c] <= 1'b0;
          end
          if (err_ev) begin
            ch_err_flag[c] <= 1'b1;
          end else if (ch_flag_clear[c]) begin
            ch_err_flag[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // mdc_controller
`default_nettype wire

/* File: tb/mdc_controller_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Controller port checks
// ****************************************
module mdc_ctrl_checker #(
  parameter int NCH = 7,
  parameter int CW = 17
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel side
  input wire logic [NCH-1:0] ch_enable,
  input wire logic [NCH-1:0] ch_flag_clear,
  input wire logic [NCH-1:0] ch_half_flag,
  input wire logic [NCH-1:0] ch_done_flag,
  input wire logic [NCH-1:0] ch_err_flag,
  input wire logic [NCH-1:0] ch_irq,
  // Bus side
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic bus_ack,
  input wire logic bus_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // One item is an accepted read beat, then a write beat
  sequence s_rd;
    bus_req && !bus_write && bus_ack && !bus_err;
  endsequence
  sequence s_wr;
    bus_req && bus_write && bus_ack && !bus_err;
  endsequence
  a_irq_or_flags: assert property (
    ch_irq == (ch_half_flag | ch_done_flag | ch_err_flag))
    else $error("irq differs from the flags");
  a_req_holds: assert property (
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_write))
    else $error("request dropped or changed before ack");
  a_write_follows: assert property (s_rd |=> bus_req && bus_write)
    else $error("read not followed by write");
  a_done_gap: assert property (s_wr |=> !bus_req)
    else $error("no done cycle after write");
  a_err_flag: assert property (
    bus_req && bus_err |-> ##[1:2] ch_err_flag != '0)
    else $error("bus error left no error flag");
  a_done_cause: assert property (
    (ch_done_flag & ~$past(ch_done_flag)) != '0 |->
      $past(bus_ack && bus_write && !bus_err))
    else $error("done flag without a finished write");
  a_size_legal: assert property (bus_req |-> bus_size != 2'h3)
    else $error("illegal transfer size");
  a_no_spurious: assert property (
    ch_enable == '0 && $past(ch_enable) == '0 && !bus_req |=> !bus_req)
    else $error("request with no channel enabled");
  a_clear_flags: assert property (
    ch_flag_clear == '1 && !bus_req && !$past(bus_req) |=>
      ch_done_flag == '0 && ch_half_flag == '0)
    else $error("flags not cleared");
endmodule // mdc_ctrl_checker
bind mdc_controller mdc_ctrl_checker #(.NCH(NCH), .CW(CW)) u_chk (
  .clk, .rst, .ch_enable, .ch_flag_clear, .ch_half_flag, .ch_done_flag,
  .ch_err_flag, .ch_irq, .bus_req, .bus_write, .bus_addr, .bus_size,
  .bus_ack, .bus_err);
`default_nettype wire

/* File: tb/mdc_bus_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bus target model
// ****************************************
module mdc_bus_mem (
  // Clock
  input wire logic clk,
  // Master request
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_wdata,
  // Answer
  output logic bus_ack,
  output logic bus_err,
  output logic [31:0] bus_rdata,
  // Behaviour controls
  input wire logic slow,
  input wire logic [31:0] err_addr
);
  logic [31:0] m [16384];
  logic [31:0] last_reg = 32'h0000_0000;
  logic tgl_reg = 1'b0;
  // Any address may be source or destination; slow answers every other cycle
  assign bus_ack = bus_req && (!slow || tgl_reg);
  assign bus_err = bus_ack && bus_addr == err_addr;
  // Idle data lines show the inverse of the last value, never a stale copy
  assign bus_rdata = bus_ack ? m[bus_addr[15:2]] : ~last_reg;
  // Preload a pattern the bench can recompute
  initial begin
    for (int i = 0; i < 16384; i++) m[i] = {~i[15:0], i[15:0]};
  end
  // Narrow writes keep only the low bits
  always @(posedge clk) begin
    tgl_reg <= !tgl_reg;
    if (bus_ack) last_reg <= bus_write ? bus_wdata : bus_rdata;
    if (bus_ack && bus_write && !bus_err) begin
      m[bus_addr[15:2]] <= bus_wdata & (bus_size == 2'h0 ? 32'h0000_00FF :
        bus_size == 2'h1 ? 32'h0000_FFFF : 32'hFFFF_FFFF);
    end
  end
endmodule // mdc_bus_mem
`default_nettype wire

/* File: tb/tb_multichannel_dma_controller.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Controller testbench
// ****************************************
module tb_multichannel_dma_controller;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] ch_enable, ch_sw_trigger, ch_circular, ch_flag_clear;
  logic [6:0] periph_req, ch_half_flag, ch_done_flag, ch_err_flag, ch_irq;
  logic [13:0] ch_priority, ch_src_size, ch_dst_size;
  logic [223:0] ch_src_addr, ch_dst_addr;
  logic [118:0] ch_items, ch_remaining;
  logic bus_req, bus_write, bus_ack, bus_err, slow;
  logic [1:0] bus_size;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, err_addr;
  int fails = 0;
  int tests_run = 0;
  int k;
  mdc_controller dut (.clk, .rst, .ch_enable, .ch_sw_trigger, .ch_circular,
    .ch_priority, .ch_src_size, .ch_dst_size, .ch_src_addr, .ch_dst_addr,
    .ch_items, .ch_flag_clear, .periph_req, .ch_half_flag, .ch_done_flag,
    .ch_err_flag, .ch_irq, .ch_remaining, .bus_req, .bus_write, .bus_addr,
    .bus_size, .bus_wdata, .bus_ack, .bus_err, .bus_rdata);
  mdc_bus_mem mem (.clk, .bus_req, .bus_write, .bus_addr, .bus_size,
    .bus_wdata, .bus_ack, .bus_err, .bus_rdata, .slow, .err_addr);
  // Free-running 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Arm one channel; addresses are set once, word aligned for all sizes
  task automatic cfg(input int c, input logic [1:0] p, s, d,
                     input logic [16:0] n, input logic cr);
    ch_priority[2*c+:2] <= p;
    ch_src_size[2*c+:2] <= s;
    ch_dst_size[2*c+:2] <= d;
    ch_items[17*c+:17] <= n;
    ch_circular[c] <= cr;
    ch_enable[c] <= 1'b1;
  endtask
  // Bounded wait for a channel to finish or fail
  task automatic wait_flag(input int c);
    for (k = 0; k < 3000 && (ch_done_flag[c] | ch_err_flag[c]) !== 1'b1;
         k++) @(posedge clk);
    if (k == 3000) begin
      fails++;
      end_sim();
    end
  endtask
  // Bounded wait for the next bus request
  task automatic wait_req();
    for (k = 0; k < 100 && bus_req !== 1'b1; k++) @(posedge clk);
    if (k == 100) begin
      fails++;
      end_sim();
    end
  endtask
  // Disarm everything and clear all flags between tests
  task automatic stop(input string name);
    @(posedge clk);
    ch_enable <= '0;
    ch_sw_trigger <= '0;
    periph_req <= '0;
    ch_flag_clear <= '1;
    @(posedge clk);
    ch_flag_clear <= '0;
    repeat (4) @(posedge clk);
    $display("Test %s finished", name);
  endtask
  initial begin
    {ch_enable, ch_sw_trigger, ch_circular, ch_flag_clear, periph_req} = '0;
    {ch_priority, ch_src_size, ch_dst_size, ch_items} = '0;
    slow = 1'b0;
    err_addr = 32'hFFFF_FFFC;
    for (int c = 0; c < 7; c++) begin
      ch_src_addr[32*c+:32] = 32'h0000_1000 + 32'(c) * 32'h0000_0100;
      ch_dst_addr[32*c+:32] = 32'h0000_8000 + 32'(c) * 32'h0000_0100;
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({ch_half_flag, ch_done_flag, ch_irq}), 32'h0000_0000);
    // Four words by software trigger, memory to memory
    cfg(2, 2'h1, 2'h2, 2'h2, 17'h0_0004, 1'b0);
    ch_sw_trigger[2] <= 1'b1;
    wait_flag(2);
    @(posedge clk);
    chk(32'({ch_half_flag[2], ch_done_flag[2], ch_irq[2]}), 32'h7);
    chk(32'(ch_remaining[34+:17]), 32'h0);
    chk(mem.m[8192+128], {~16'(1152), 16'(1152)});
    stop("count");
    // Three width pairings: byte to word, half to half, word to byte
    for (int s = 0; s < 3; s++) begin
      cfg(3, 2'h0, 2'(s), 2'(2 - s), 17'h0_0001, 1'b0);
      ch_sw_trigger[3] <= 1'b1;
      wait_flag(3);
      repeat (2) @(posedge clk);
      chk(mem.m[8192+192], s == 1 ? 32'h0000_04C0 : 32'h0000_00C0);
      stop("width");
    end
    // A tie at the lowest level first, then channel 6 winning at each higher level
    for (int p = 0; p < 4; p++) begin
      cfg(0, p == 0 ? 2'h0 : 2'(p - 1), 2'h2, 2'h2, 17'h0_0001, 1'b0);
      cfg(6, 2'(p), 2'h2, 2'h2, 17'h0_0001, 1'b0);
      repeat (3) @(posedge clk);
      ch_sw_trigger <= 7'h41;
      wait_req();
      chk(bus_addr, p == 0 ? 32'h0000_1000 : 32'h0000_1600);
      wait_flag(0);
      wait_flag(6);
      stop("priority");
    end
    // Bus error on the write beat
    err_addr <= 32'h0000_8400;
    cfg(4, 2'h2, 2'h2, 2'h2, 17'h0_0001, 1'b0);
    ch_sw_trigger[4] <= 1'b1;
    wait_flag(4);
    @(posedge clk);
    chk(32'({ch_err_flag[4], ch_done_flag[4], ch_irq[4]}), 32'h5);
    err_addr <= 32'hFFFF_FFFC;
    stop("error");
    // Circular mode keeps running after the last item
    cfg(5, 2'h3, 2'h2, 2'h2, 17'h0_0002, 1'b1);
    ch_sw_trigger[5] <= 1'b1;
    wait_flag(5);
    @(posedge clk);
    wait_req();
    chk(32'(ch_remaining[85+:17]), 32'h0000_0002);
    stop("circular");
    // Hardware request, slow target, largest count
    slow <= 1'b1;
    cfg(1, 2'h1, 2'h2, 2'h2, 17'h1_0000, 1'b0);
    periph_req[1] <= 1'b1;
    for (k = 0; k < 200 && ch_remaining[17+:17] !== 17'h0_FFFF; k++)
      @(posedge clk);
    chk(32'(ch_remaining[17+:17]), 32'h0000_FFFF);
    if (k == 200) end_sim();
    chk(mem.m[8192+64], {~16'(1088), 16'(1088)});
    stop("hardware");
    end_sim();
  end
endmodule // tb_multichannel_dma_controller
`default_nettype wire
